/* File: include/debug_serial_consts.vh */
`ifndef DEBUG_SERIAL_CONSTS_VH
`define DEBUG_SERIAL_CONSTS_VH

`define DS_CLK_PERIOD_NS   50
`define DS_DATA_BITS       8
`define DS_FRAME_BITS      10
`define DS_CAL_CHAR        8'h80
`define DS_CAL_SHIFT       3
`define DS_MAX_DIV         512
`define DS_PER_W           10
`define DS_LINE_IDLE       1'b1
`define DS_START_LVL       1'b0
`define DS_STOP_LVL        1'b1

`define DS_ST_CAL_WAIT     3'h0
`define DS_ST_CAL_MEAS     3'h1
`define DS_ST_IDLE         3'h2
`define DS_ST_START        3'h3
`define DS_ST_DATA         3'h4
`define DS_ST_STOP         3'h5

`endif

/* File: rtl/debug_serial_tx.v */
`timescale 1ns/1ps
`include "debug_serial_consts.vh"

module debug_serial_tx #(
	parameter PER_W = `DS_PER_W
) (
	// clock and reset
	input  wire             clk_i,
	input  wire             resetn_i,
	// bit period and request
	input  wire [PER_W-1:0] period_i,
	input  wire             start_i,
	input  wire [7:0]       data_i,
	// line side
	output reg              line_o,
	output reg              busy_o
);

	reg [8:0]       shift_r;
	reg [3:0]       bits_r;
	reg [PER_W-1:0] cnt_r;

	////////////////////////////////////////////////////////////////////////
	// one start bit, eight data bits lsb first, one stop bit, each bit held
	// for the measured period
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			line_o  <= `DS_LINE_IDLE;
			busy_o  <= 1'b0;
			shift_r <= 9'h1FF;
			bits_r  <= 4'h0;
			cnt_r   <= {PER_W{1'b0}};
		end else if (!busy_o) begin
			if (start_i) begin
				line_o  <= `DS_START_LVL;
				shift_r <= {`DS_STOP_LVL, data_i};
				bits_r  <= 4'h9;
				cnt_r   <= period_i - {{(PER_W-1){1'b0}}, 1'b1};
				busy_o  <= 1'b1;
			end
		end else if (cnt_r != {PER_W{1'b0}}) begin
			cnt_r <= cnt_r - {{(PER_W-1){1'b0}}, 1'b1};
		end else if (bits_r == 4'h0) begin
			busy_o <= 1'b0;
			line_o <= `DS_LINE_IDLE;
		end else begin
			line_o  <= shift_r[0];
			shift_r <= {1'b1, shift_r[8:1]};
			bits_r  <= bits_r - 4'h1;
			cnt_r   <= period_i - {{(PER_W-1){1'b0}}, 1'b1};
		end
	end

endmodule

/* File: rtl/debug_serial_autobaud.v */
`timescale 1ns/1ps
`include "debug_serial_consts.vh"

module debug_serial_autobaud #(
	parameter PER_W = `DS_PER_W
) (
	// clock and reset
	input  wire             CLK_I,
	input  wire             RESETN_I,
	// one-wire debug pin
	input  wire             DEBUG_SERIAL_PIN_I,
	output wire             DEBUG_SERIAL_PIN_O,
	output wire             DEBUG_SERIAL_PIN_OE_O,
	// power mode and reset request
	input  wire             HALT_MODE_I,
	output reg              SYS_RESET_REQ_O,
	// received characters
	output reg  [7:0]       RX_DATA_O,
	output reg              RX_VALID_O,
	output reg              RX_FRAME_ERR_O,
	// characters to send
	input  wire [7:0]       TX_DATA_I,
	input  wire             TX_VALID_I,
	output wire             TX_READY_O,
	// calibration state
	output reg              BAUD_LOCKED_O,
	output reg  [PER_W-1:0] BIT_PERIOD_O
);

	localparam MEAS_W = PER_W + `DS_CAL_SHIFT;

	localparam [2:0] ST_CAL_WAIT = `DS_ST_CAL_WAIT;
	localparam [2:0] ST_CAL_MEAS = `DS_ST_CAL_MEAS;
	localparam [2:0] ST_IDLE     = `DS_ST_IDLE;
	localparam [2:0] ST_START    = `DS_ST_START;
	localparam [2:0] ST_DATA     = `DS_ST_DATA;
	localparam [2:0] ST_STOP     = `DS_ST_STOP;

	localparam [PER_W-1:0]  PER_ONE  = {{(PER_W-1){1'b0}}, 1'b1};
	localparam [MEAS_W-1:0] MEAS_ONE = {{(MEAS_W-1){1'b0}}, 1'b1};

	reg  [2:0]        state_r;
	reg  [2:0]        state_nxt;
	reg  [MEAS_W-1:0] meas_r;
	reg  [MEAS_W-1:0] meas_nxt;
	reg  [PER_W-1:0]  cnt_r;
	reg  [PER_W-1:0]  cnt_nxt;
	reg  [2:0]        bit_r;
	reg  [2:0]        bit_nxt;
	reg  [7:0]        shift_r;
	reg  [7:0]        shift_nxt;
	reg  [PER_W-1:0]  period_nxt;
	reg               locked_nxt;
	reg  [7:0]        rx_data_nxt;
	reg               rx_valid_nxt;
	reg               rx_err_nxt;
	reg               pin_prev_r;

	wire              tx_busy;
	wire              tx_start;
	wire              tx_line;
	wire [PER_W-1:0]  half_per;
	wire [PER_W-1:0]  meas_per;
	wire              pin;

	assign pin = DEBUG_SERIAL_PIN_I;

	// mid-bit offset from the first low cycle; zero for one or two clocks
	assign half_per = (BIT_PERIOD_O - PER_ONE) >> 1;

	// eight low bits were timed, so one bit is the count over eight
	assign meas_per = meas_r[MEAS_W-1:`DS_CAL_SHIFT];

	////////////////////////////////////////////////////////////////////////
	// calibration and receive sequencing, all on the system clock
	always @* begin
		state_nxt    = state_r;
		meas_nxt     = meas_r;
		cnt_nxt      = cnt_r;
		bit_nxt      = bit_r;
		shift_nxt    = shift_r;
		period_nxt   = BIT_PERIOD_O;
		locked_nxt   = BAUD_LOCKED_O;
		rx_data_nxt  = RX_DATA_O;
		rx_valid_nxt = 1'b0;
		rx_err_nxt   = 1'b0;
		case (state_r)
			ST_CAL_WAIT: begin
				// receive and transmit wait for the lock; calibration starts when the pin is first sampled low
				if (pin == `DS_START_LVL) begin
					meas_nxt  = MEAS_ONE;
					state_nxt = ST_CAL_MEAS;
				end
			end
			ST_CAL_MEAS: begin
				// 80H gives one unbroken low run of eight bit times
				if (pin == `DS_START_LVL) begin
					// saturate rather than wrap on a too-slow host
					if (meas_r != {MEAS_W{1'b1}}) begin
						meas_nxt = meas_r + MEAS_ONE;
					end
				end else begin
					if (meas_per == {PER_W{1'b0}}) begin
						period_nxt = PER_ONE;
					end else begin
						period_nxt = meas_per;
					end
					locked_nxt = 1'b1;
					// the high tail of 80H simply reads as idle line
					state_nxt  = ST_IDLE;
				end
			end
			ST_IDLE: begin
				// own transmission is not echoed into the receiver; a start
				// is a falling edge, so a line left low after a bad stop bit
				// is not read as an endless run of frames
				if (pin == `DS_START_LVL && pin_prev_r == `DS_LINE_IDLE
						&& !tx_busy) begin
					bit_nxt = 3'h0;
					if (half_per == {PER_W{1'b0}}) begin
						cnt_nxt   = BIT_PERIOD_O - PER_ONE;
						state_nxt = ST_DATA;
					end else begin
						cnt_nxt   = half_per - PER_ONE;
						state_nxt = ST_START;
					end
				end
			end
			ST_START: begin
				if (cnt_r != {PER_W{1'b0}}) begin
					cnt_nxt = cnt_r - PER_ONE;
				end else if (pin == `DS_START_LVL) begin
					cnt_nxt   = BIT_PERIOD_O - PER_ONE;
					state_nxt = ST_DATA;
				end else begin
					// glitch shorter than half a bit: not a start bit
					state_nxt = ST_IDLE;
				end
			end
			ST_DATA: begin
				if (cnt_r != {PER_W{1'b0}}) begin
					cnt_nxt = cnt_r - PER_ONE;
				end else begin
					shift_nxt = {pin, shift_r[7:1]};
					cnt_nxt   = BIT_PERIOD_O - PER_ONE;
					bit_nxt   = bit_r + 3'h1;
					if (bit_r == 3'h7) begin
						state_nxt = ST_STOP;
					end
				end
			end
			ST_STOP: begin
				if (cnt_r != {PER_W{1'b0}}) begin
					cnt_nxt = cnt_r - PER_ONE;
				end else begin
					// leaving at mid stop bit leaves half a bit of slack
					state_nxt = ST_IDLE;
					if (pin == `DS_STOP_LVL) begin
						rx_data_nxt  = shift_r;
						rx_valid_nxt = 1'b1;
					end else begin
						rx_err_nxt = 1'b1;
					end
				end
			end
			default: begin
				state_nxt = ST_CAL_WAIT;
			end
		endcase
	end

	always @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			state_r        <= ST_CAL_WAIT;
			meas_r         <= {MEAS_W{1'b0}};
			cnt_r          <= {PER_W{1'b0}};
			bit_r          <= 3'h0;
			shift_r        <= 8'h00;
			BIT_PERIOD_O   <= PER_ONE;
			BAUD_LOCKED_O  <= 1'b0;
			RX_DATA_O      <= 8'h00;
			RX_VALID_O     <= 1'b0;
			RX_FRAME_ERR_O <= 1'b0;
			pin_prev_r     <= `DS_LINE_IDLE;
		end else begin
			pin_prev_r     <= pin;
			state_r        <= state_nxt;
			meas_r         <= meas_nxt;
			cnt_r          <= cnt_nxt;
			bit_r          <= bit_nxt;
			shift_r        <= shift_nxt;
			BIT_PERIOD_O   <= period_nxt;
			BAUD_LOCKED_O  <= locked_nxt;
			RX_DATA_O      <= rx_data_nxt;
			RX_VALID_O     <= rx_valid_nxt;
			RX_FRAME_ERR_O <= rx_err_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// halt-mode wake: a low pin asks the reset logic for a system reset
	always @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			SYS_RESET_REQ_O <= 1'b0;
		end else begin
			SYS_RESET_REQ_O <= HALT_MODE_I & (pin == 1'b0);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmitter: refused until calibrated and while a frame is receiving
	assign TX_READY_O = BAUD_LOCKED_O & ~tx_busy & (state_r == ST_IDLE);
	assign tx_start   = TX_VALID_I & TX_READY_O;

	debug_serial_tx #(
		.PER_W    (PER_W)
	) u_tx (
		.clk_i    (CLK_I),
		.resetn_i (RESETN_I),
		.period_i (BIT_PERIOD_O),
		.start_i  (tx_start),
		.data_i   (TX_DATA_I),
		.line_o   (tx_line),
		.busy_o   (tx_busy)
	);

	// pin is driven only for the length of an outgoing frame
	assign DEBUG_SERIAL_PIN_O    = tx_line;
	assign DEBUG_SERIAL_PIN_OE_O = tx_busy;

endmodule

/* File: verif/debug_serial_autobaud_asserts.sv */
`timescale 1ns/1ps
module debug_serial_autobaud_asserts #(
	parameter PER_W = 10
) (
	// clock and reset
	input wire             CLK_I,
	input wire             RESETN_I,
	// pin and halt
	input wire             DEBUG_SERIAL_PIN_I,
	input wire             DEBUG_SERIAL_PIN_O,
	input wire             DEBUG_SERIAL_PIN_OE_O,
	input wire             HALT_MODE_I,
	input wire             SYS_RESET_REQ_O,
	// user side
	input wire             RX_VALID_O,
	input wire             RX_FRAME_ERR_O,
	input wire             TX_VALID_I,
	input wire             TX_READY_O,
	input wire             BAUD_LOCKED_O,
	input wire [PER_W-1:0] BIT_PERIOD_O
);
	reg  [13:0] oe_cnt_r;
	wire [13:0] per = {{(14-PER_W){1'b0}}, BIT_PERIOD_O};
	wire        oe = DEBUG_SERIAL_PIN_OE_O;

	// counts driven cycles, so frame length needs no long repetition
	always @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I)
			oe_cnt_r <= 14'h0;
		else
			oe_cnt_r <= oe ? oe_cnt_r + 14'h1 : 14'h0;
	end
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);
	sequence cal_end;
		!BAUD_LOCKED_O && !DEBUG_SERIAL_PIN_I ##1 DEBUG_SERIAL_PIN_I;
	endsequence
	sequence tx_take;
		TX_VALID_I && TX_READY_O;
	endsequence
	halt_set_a: assert property (HALT_MODE_I && !DEBUG_SERIAL_PIN_I
		|=> SYS_RESET_REQ_O) else $error("halt reset missing");
	halt_clr_a: assert property (!(HALT_MODE_I && !DEBUG_SERIAL_PIN_I)
		|=> !SYS_RESET_REQ_O) else $error("spurious reset");
	quiet_unlock_a: assert property (!BAUD_LOCKED_O |-> !TX_READY_O
		&& !oe && !RX_VALID_O && !RX_FRAME_ERR_O) else $error("not idle");
	lock_time_a: assert property (cal_end |=> BAUD_LOCKED_O)
		else $error("lock late");
	lock_hold_a: assert property (BAUD_LOCKED_O |=> BAUD_LOCKED_O
		&& $stable(BIT_PERIOD_O)) else $error("period moved");
	tx_start_a: assert property (tx_take |=> oe && !DEBUG_SERIAL_PIN_O)
		else $error("no start bit");
	stop_bit_a: assert property (oe && oe_cnt_r >= per * 14'h9
		|-> DEBUG_SERIAL_PIN_O) else $error("stop bit low");
	frame_len_a: assert property ($fell(oe) |-> oe_cnt_r == per * 14'hA)
		else $error("frame length");
	rx_pulse_a: assert property (RX_VALID_O || RX_FRAME_ERR_O
		|=> !RX_VALID_O && !RX_FRAME_ERR_O) else $error("pulse too long");
endmodule

/* File: verif/debug_host_model.sv */
`timescale 1ns/1ps
module debug_host_model (
	// system clock
	input  wire clk_i,
	// host drive; the model drives the line high when released
	output reg  line_o
);
	initial line_o = 1'b1;
	task drive(input v);
		line_o = v;
	endtask
	// bit period p in clocks; callers use p = 4 except in the loop over periods 1, 8 and 512
	task send(input [7:0] d, input integer p, input stp);
		integer k;
		reg [9:0] f;
		begin
			f = {stp, d, 1'b0};
			for (k = 0; k < 10; k = k + 1) begin
				line_o = f[k];
				repeat (p) @(posedge clk_i);
				#1;
			end
			// a high stop bit already rests the line, so back-to-back calls
			// never assign it twice in one step; a low one is released here
			if (!stp)
				line_o = 1'b1;
		end
	endtask
endmodule

/* File: verif/debug_serial_autobaud_tb.sv */
`timescale 1ns/1ps
module debug_serial_autobaud_tb;
	reg        CLK_I = 1'b0;
	reg        RESETN_I = 1'b0;
	reg        HALT_MODE_I = 1'b0;
	reg  [7:0] TX_DATA_I = 8'h00;
	reg        TX_VALID_I = 1'b0;
	wire       pin_o, pin_oe, host_o, rst_req, rx_v, rx_e, rdy, lck;
	wire [7:0] rx_d;
	wire [9:0] per;
	integer    mismatches = 0, compares = 0, nrx = 0, nerr = 0, n0, k, p;
	reg  [7:0] got = 8'h00;
	// host never drives while the device does, so the mux is the wire
	wire       pin = pin_oe ? pin_o : host_o;

	always #25 CLK_I = ~CLK_I;
	always @(posedge CLK_I) begin
		if (rx_v === 1'b1) begin
			got <= rx_d;
			nrx <= nrx + 1;
		end
		if (rx_e === 1'b1)
			nerr <= nerr + 1;
	end
	debug_host_model i_debug_host_model (.clk_i(CLK_I), .line_o(host_o));
	debug_serial_autobaud i_debug_serial_autobaud (
		.CLK_I(CLK_I), .RESETN_I(RESETN_I), .DEBUG_SERIAL_PIN_I(pin),
		.DEBUG_SERIAL_PIN_O(pin_o), .DEBUG_SERIAL_PIN_OE_O(pin_oe),
		.HALT_MODE_I(HALT_MODE_I), .SYS_RESET_REQ_O(rst_req),
		.RX_DATA_O(rx_d), .RX_VALID_O(rx_v), .RX_FRAME_ERR_O(rx_e),
		.TX_DATA_I(TX_DATA_I), .TX_VALID_I(TX_VALID_I), .TX_READY_O(rdy),
		.BAUD_LOCKED_O(lck), .BIT_PERIOD_O(per));

	task chk(input [15:0] g, input [15:0] e);
		begin
			compares = compares + 1;
			if (g !== e) begin
				mismatches = mismatches + 1;
				$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
			end
		end
	endtask
	task results;
		begin
			$display("compares=%0d mismatches=%0d", compares, mismatches);
			if (mismatches == 0 && compares > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	task tick(input integer n);
		begin
			repeat (n) @(posedge CLK_I);
			#1;
		end
	endtask
	task cal(input integer q);
		begin
			RESETN_I = 1'b0;
			tick(10);
			RESETN_I = 1'b1;
			tick(1);
			i_debug_host_model.send(8'h80, q, 1'b1);
			tick(4);
			chk(lck, 1);
			chk(per, q);
		end
	endtask
	task quiet;
		begin
			TX_VALID_I = 1'b1;
			tick(20);
			chk(pin_oe, 0);
			chk(rdy, 0);
			chk(lck, 0);
			TX_VALID_I = 1'b0;
		end
	endtask
	task rx_pair;
		begin
			n0 = nrx;
			i_debug_host_model.send(8'hA5, 4, 1'b1);
			chk(got, 8'hA5);
			i_debug_host_model.send(8'h3C, 4, 1'b1);
			tick(3);
			chk(nrx - n0, 2);
			chk(got, 8'h3C);
		end
	endtask
	task rxb(input [7:0] d, input integer q, input stp);
		integer   e0;
		reg [7:0] g0;
		begin
			n0 = nrx;
			e0 = nerr;
			g0 = got;
			i_debug_host_model.send(d, q, stp);
			tick(3);
			chk(nrx - n0, stp);
			chk(nerr - e0, !stp);
			chk(got, stp ? d : g0);
		end
	endtask
	task txb(input [7:0] d, input integer q);
		integer w;
		reg [9:0] f;
		begin
			for (w = 0; w < 100 && rdy !== 1'b1; w = w + 1)
				tick(1);
			TX_DATA_I = d;
			TX_VALID_I = 1'b1;
			tick(1);
			TX_VALID_I = 1'b0;
			for (w = 0; w < 10; w = w + 1) begin
				f[w] = pin & pin_oe;
				tick(q);
			end
			chk(f, {1'b1, d, 1'b0});
			chk(pin_oe, 0);
		end
	endtask
	task halt;
		begin
			HALT_MODE_I = 1'b1;
			i_debug_host_model.drive(1'b0);
			tick(1);
			chk(rst_req, 1);
			i_debug_host_model.drive(1'b1);
			tick(1);
			chk(rst_req, 0);
			HALT_MODE_I = 1'b0;
		end
	endtask

	initial begin
		tick(10);
		RESETN_I = 1'b1;
		quiet;
		cal(4);
		rx_pair;
		rxb(8'hE7, 4, 1'b0);
		txb(8'h5A, 4);
		for (k = 0; k < 3; k = k + 1) begin
			p = (k == 0) ? 1 : (k == 1) ? 8 : 512;
			cal(p);
			rxb(8'hC3, p, 1'b1);
			txb(8'h96, p);
		end
		halt;
		results;
	end
	initial begin
		#4000000;
		mismatches = mismatches + 1;
		results;
	end
endmodule

bind debug_serial_autobaud debug_serial_autobaud_asserts #(.PER_W(PER_W))
	i_debug_serial_autobaud_asserts (
	.CLK_I(CLK_I), .RESETN_I(RESETN_I),
	.DEBUG_SERIAL_PIN_I(DEBUG_SERIAL_PIN_I),
	.DEBUG_SERIAL_PIN_O(DEBUG_SERIAL_PIN_O),
	.DEBUG_SERIAL_PIN_OE_O(DEBUG_SERIAL_PIN_OE_O),
	.HALT_MODE_I(HALT_MODE_I), .SYS_RESET_REQ_O(SYS_RESET_REQ_O),
	.RX_VALID_O(RX_VALID_O), .RX_FRAME_ERR_O(RX_FRAME_ERR_O),
	.TX_VALID_I(TX_VALID_I), .TX_READY_O(TX_READY_O),
	.BAUD_LOCKED_O(BAUD_LOCKED_O), .BIT_PERIOD_O(BIT_PERIOD_O));
